// ==== cie_pkg.sv ====
// Purpose: constants and types for the can interrupt enable logic
// Assumes: 32-bit ahb-lite register bus, word aligned registers
// Notes:   offsets are byte addresses inside a 64-byte window
package cie_pkg;
  localparam logic [5:0] CIE_OFS_ENABLE  = 6'h00;
  localparam logic [5:0] CIE_OFS_STATUS  = 6'h04;
  localparam logic [5:0] CIE_OFS_CTRL    = 6'h08;
  localparam logic [5:0] CIE_OFS_IRQ_ST  = 6'h0C;
  localparam logic [5:0] CIE_OFS_IRQ_MSK = 6'h10;
  localparam int CIE_WINDOW_BYTES = 64;
  localparam logic [7:0] CIE_ENABLE_RST = 8'h00;
  localparam int CIE_BIT_WUP  = 7;
  localparam int CIE_BIT_CSC  = 6;
  localparam int CIE_BIT_RXS  = 4;
  localparam int CIE_BIT_TXS  = 2;
  localparam int CIE_BIT_OVR  = 1;
  localparam int CIE_BIT_RXF  = 0;
  localparam int CIE_BIT_INIT_RQ  = 0;
  localparam int CIE_BIT_WUP_FEN  = 1;
  localparam logic [1:0] CIE_SENS_NONE = 2'h0;
  localparam logic [1:0] CIE_SENS_BOFF = 2'h1;
  localparam logic [1:0] CIE_SENS_ERR  = 2'h2;
  localparam logic [1:0] CIE_SENS_ALL  = 2'h3;

  typedef enum logic [1:0] {
    CIE_ST_OK   = 2'b00,
    CIE_ST_WARN = 2'b01,
    CIE_ST_ERR  = 2'b10,
    CIE_ST_BOFF = 2'b11
  } cie_state_t;

  typedef struct packed {
    logic wakeup;
    logic rx_full;
    logic overrun;
  } cie_events_t;

  typedef struct packed {
    logic wakeup;
    logic error;
    logic receive;
  } cie_irq_t;
endpackage

// ==== cie_top.sv ====
// Purpose: interrupt enable and status change sensitivity of a can unit
// Assumes: ahb-lite slave, zero wait states, single word transfers
// Notes:   events and controller states come from the same clock domain
//
// Overview of operation
// - wakeup, status change, overrun and rx full enables reset while init fully active
// - enable writes only outside initialization
// - sensitivity fields unaffected by initialization
// - wakeup enable gates wakeup request
// - status change enable gates error request
// - receiver sensitivity selects counted transitions
// - receiver flags update only without pending change
// - transmitter sensitivity selects counted transitions
// - transmitter flags update only without pending change
// - overrun enable gates error request
// - receive full enable gates receiver request
// - receiver bus-off state; tx recovery forces ok
// - register window spans 64 bytes
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module cie_top (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic               init_acknowledge,
  input  wire cie_pkg::cie_events_t events,
  input  wire logic [1:0]         rx_state_code,
  input  wire logic [1:0]         tx_state_code,
  output logic                    init_request,
  output logic                    wakeup_function_en,
  output cie_pkg::cie_irq_t       irq_req,
  output logic                    irq
);

  logic [7:0]  can_interrupt_enable_q;
  logic        status_change_flag_q;
  logic [1:0]  rx_state_flags_q;
  logic [1:0]  tx_state_flags_q;
  logic        ev_wakeup_q;
  logic        ev_rx_full_q;
  logic        ev_overrun_q;
  logic [3:0]  irq_st_q;
  logic [3:0]  irq_msk_q;
  logic        wr_pend_q;
  logic [5:0]  wr_addr_q;
  logic        init_mode;
  logic        wr_ok;
  logic        csc_event;
  logic [1:0]  rx_new;
  logic        rx_hit;
  logic        tx_hit;
  logic [3:0]  irq_ev;
  logic        rd_sel;
  logic [31:0] rd_d;

  // byte offset inside the 64-byte window
  function automatic logic [5:0] win_ofs(input logic [31:0] a);
    win_ofs = a[5:0];
  endfunction

  // does a transition touch the chosen sensitivity class
  function automatic logic sens_hit(input logic [1:0] sens, input logic [1:0] o,
                                    input logic [1:0] n);
    sens_hit = 1'b0;
    if (o != n) begin
      unique case (sens)
        cie_pkg::CIE_SENS_NONE: sens_hit = 1'b0;
        cie_pkg::CIE_SENS_BOFF: sens_hit = (o == cie_pkg::CIE_ST_BOFF) ||
                                           (n == cie_pkg::CIE_ST_BOFF);
        cie_pkg::CIE_SENS_ERR:  sens_hit = (o[1] != n[1]);
        cie_pkg::CIE_SENS_ALL:  sens_hit = 1'b1;
      endcase
    end
  endfunction

  assign init_mode = init_request && init_acknowledge;
  assign wr_ok     = !init_request && !init_acknowledge;

  // transmitter recovery drags the receiver straight to ok
  assign rx_new = (tx_state_flags_q == cie_pkg::CIE_ST_BOFF &&
                   tx_state_code == cie_pkg::CIE_ST_OK) ? cie_pkg::CIE_ST_OK
                                                        : rx_state_code;
  assign rx_hit = sens_hit(can_interrupt_enable_q[cie_pkg::CIE_BIT_RXS +: 2],
                           rx_state_flags_q, rx_new);
  assign tx_hit = sens_hit(can_interrupt_enable_q[cie_pkg::CIE_BIT_TXS +: 2],
                           tx_state_flags_q, tx_state_code);
  assign csc_event = !status_change_flag_q && (rx_hit || tx_hit);

  // ahb address phase capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 6'h00;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      wr_addr_q <= win_ofs(haddr);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // enable register; sensitivity fields outlive init mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      can_interrupt_enable_q <= cie_pkg::CIE_ENABLE_RST;
    end else begin
      if (wr_pend_q && wr_addr_q == cie_pkg::CIE_OFS_ENABLE) begin
        if (wr_ok) begin
          can_interrupt_enable_q <= hwdata[7:0];
        end else begin
          can_interrupt_enable_q[5:2] <= hwdata[5:2];
        end
      end
      // init clear overrides the write on the gated bits
      if (init_mode) begin
        can_interrupt_enable_q[cie_pkg::CIE_BIT_WUP] <= 1'b0;
        can_interrupt_enable_q[cie_pkg::CIE_BIT_CSC] <= 1'b0;
        can_interrupt_enable_q[cie_pkg::CIE_BIT_OVR] <= 1'b0;
        can_interrupt_enable_q[cie_pkg::CIE_BIT_RXF] <= 1'b0;
      end
    end
  end

  // control bits toward the can core
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      init_request       <= 1'b0;
      wakeup_function_en <= 1'b0;
    end else if (wr_pend_q && wr_addr_q == cie_pkg::CIE_OFS_CTRL) begin
      init_request       <= hwdata[cie_pkg::CIE_BIT_INIT_RQ];
      wakeup_function_en <= hwdata[cie_pkg::CIE_BIT_WUP_FEN];
    end
  end

  // status change flag, set wins over write-one clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_change_flag_q <= 1'b0;
    end else if (csc_event) begin
      status_change_flag_q <= 1'b1;
    end else if (wr_pend_q && wr_addr_q == cie_pkg::CIE_OFS_STATUS &&
                 hwdata[8]) begin
      status_change_flag_q <= 1'b0;
    end
  end

  // state flags frozen while a change is pending
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_state_flags_q <= cie_pkg::CIE_ST_OK;
      tx_state_flags_q <= cie_pkg::CIE_ST_OK;
    end else if (!status_change_flag_q) begin
      rx_state_flags_q <= rx_new;
      tx_state_flags_q <= tx_state_code;
    end
  end

  // event flags, set wins over clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ev_wakeup_q  <= 1'b0;
      ev_rx_full_q <= 1'b0;
      ev_overrun_q <= 1'b0;
    end else begin
      ev_wakeup_q  <= events.wakeup ||
                      (ev_wakeup_q && !(wr_pend_q &&
                       wr_addr_q == cie_pkg::CIE_OFS_STATUS && hwdata[2]));
      ev_rx_full_q <= events.rx_full ||
                      (ev_rx_full_q && !(wr_pend_q &&
                       wr_addr_q == cie_pkg::CIE_OFS_STATUS && hwdata[0]));
      ev_overrun_q <= events.overrun ||
                      (ev_overrun_q && !(wr_pend_q &&
                       wr_addr_q == cie_pkg::CIE_OFS_STATUS && hwdata[1]));
    end
  end

  // requests are flag and enable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_req <= '0;
    end else begin
      irq_req.wakeup  <= ev_wakeup_q &&
                         can_interrupt_enable_q[cie_pkg::CIE_BIT_WUP];
      irq_req.error   <= (status_change_flag_q &&
                          can_interrupt_enable_q[cie_pkg::CIE_BIT_CSC]) ||
                         (ev_overrun_q &&
                          can_interrupt_enable_q[cie_pkg::CIE_BIT_OVR]);
      irq_req.receive <= ev_rx_full_q &&
                         can_interrupt_enable_q[cie_pkg::CIE_BIT_RXF];
    end
  end

  // sticky summary status and mask
  assign irq_ev = {events.wakeup, csc_event, events.overrun, events.rx_full};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_st_q <= 4'h0;
    end else if (wr_pend_q && wr_addr_q == cie_pkg::CIE_OFS_IRQ_ST) begin
      irq_st_q <= (irq_st_q & ~hwdata[3:0]) | irq_ev;
    end else begin
      irq_st_q <= irq_st_q | irq_ev;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_msk_q <= 4'h0;
    end else if (wr_pend_q && wr_addr_q == cie_pkg::CIE_OFS_IRQ_MSK) begin
      irq_msk_q <= hwdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st_q & irq_msk_q);
    end
  end

  // read data registered in the data phase
  assign rd_sel = hready && hsel && htrans[1] && !hwrite;

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (win_ofs(haddr))
      cie_pkg::CIE_OFS_ENABLE:  rd_d[7:0] = can_interrupt_enable_q;
      cie_pkg::CIE_OFS_STATUS:  rd_d[12:0] = {tx_state_flags_q, rx_state_flags_q,
                                              status_change_flag_q, 5'h00,
                                              ev_wakeup_q, ev_overrun_q,
                                              ev_rx_full_q};
      cie_pkg::CIE_OFS_CTRL:    rd_d[2:0] = {init_acknowledge, wakeup_function_en,
                                             init_request};
      cie_pkg::CIE_OFS_IRQ_ST:  rd_d[3:0] = irq_st_q;
      cie_pkg::CIE_OFS_IRQ_MSK: rd_d[3:0] = irq_msk_q;
      default:                  rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_sel) begin
      hrdata <= rd_d;
    end
  end

endmodule // cie_top

// ==== cie_top_properties.sv ====
// Purpose: assertions on the ports of cie_top
// Assumes: zero wait slave, registered request outputs
// Notes:   enable register mirrored from observed bus writes
`timescale 1ns/1ps
module cie_top_properties (
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [31:0]          hwdata,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic                 init_acknowledge,
  input wire cie_pkg::cie_events_t events,
  input wire logic [1:0]           rx_state_code,
  input wire logic                 init_request,
  input wire logic                 wakeup_function_en,
  input wire cie_pkg::cie_irq_t    irq_req,
  input wire logic                 irq
);
  logic       dp_wr_q;
  logic [5:0] dp_a_q;
  logic [7:0] en_q;
  logic [7:0] en_d;
  // data phase tracking
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dp_wr_q <= 1'b0;
      dp_a_q  <= 6'h00;
    end else if (hready) begin
      dp_wr_q <= hsel && htrans[1] && hwrite;
      dp_a_q  <= haddr[5:0];
    end
  end
  // enable register mirror
  always_comb begin
    en_d = en_q;
    if (dp_wr_q && dp_a_q == cie_pkg::CIE_OFS_ENABLE) begin
      en_d = (init_request || init_acknowledge) ?
             {en_q[7:6], hwdata[5:2], en_q[1:0]} : hwdata[7:0];
    end
    if (init_request && init_acknowledge) begin
      en_d = en_d & 8'h3C;
    end
  end
  always_ff @(posedge clk) begin
    en_q <= sys_rst ? cie_pkg::CIE_ENABLE_RST : en_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready okay");
  property p_ctrl; dp_wr_q && dp_a_q == cie_pkg::CIE_OFS_CTRL |=>
    init_request == $past(hwdata[0]) && wakeup_function_en == $past(hwdata[1]); endproperty
  a_ctrl: assert property (p_ctrl) else $error("control outputs not written");
  property p_init; (init_request && init_acknowledge) [*3] |-> irq_req == 3'h0; endproperty
  a_init: assert property (p_init) else $error("request during init");
  property p_wgate; irq_req.wakeup |-> $past(en_q[7]); endproperty
  a_wgate: assert property (p_wgate) else $error("wakeup request while disabled");
  property p_egate; irq_req.error |-> $past(en_q[6] || en_q[1]); endproperty
  a_egate: assert property (p_egate) else $error("error request while disabled");
  property p_rxf; events.rx_full && en_q[0] && !init_request |-> ##[1:3] irq_req.receive;
  endproperty
  a_rxf: assert property (p_rxf) else $error("receive request missing");
  property p_ovr; events.overrun && en_q[1] && !init_request |-> ##[1:3] irq_req.error;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun request missing");
  property p_csc; ((rx_state_code == 2'h3) != ($past(rx_state_code) == 2'h3)) && en_q[6]
    && en_q[5:4] == cie_pkg::CIE_SENS_BOFF |-> ##[1:3] irq_req.error; endproperty
  a_csc: assert property (p_csc) else $error("bus-off change not flagged");
  property p_hold; irq_req.receive && en_q[0] && !$past(dp_wr_q) |=> irq_req.receive;
  endproperty
  a_hold: assert property (p_hold) else $error("receive request dropped");
  c_init: cover property (init_request && init_acknowledge);
  c_err: cover property (irq_req.error);
  c_irq: cover property (irq);
endmodule // cie_top_properties
bind cie_top cie_top_properties u_props (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .init_acknowledge, .events, .rx_state_code,
  .init_request, .wakeup_function_en, .irq_req, .irq);

// ==== cie_top_tb.sv ====
// Purpose: self checking bench for cie_top
// Assumes: single slave, hready follows hreadyout
// Notes:   reads queue expected data for the monitor
`timescale 1ns/1ps
module cie_top_tb;
  localparam logic [5:0] EN = cie_pkg::CIE_OFS_ENABLE;
  localparam logic [5:0] ST = cie_pkg::CIE_OFS_STATUS;
  localparam logic [5:0] CT = cie_pkg::CIE_OFS_CTRL;
  localparam logic [5:0] IS = cie_pkg::CIE_OFS_IRQ_ST;
  localparam logic [5:0] IM = cie_pkg::CIE_OFS_IRQ_MSK;
  logic                 clk, sys_rst, hsel, hwrite, hreadyout, hresp, init_acknowledge;
  logic                 init_request, wakeup_function_en, irq, rd_dp;
  logic [31:0]          haddr, hwdata, hrdata, v;
  logic [1:0]           htrans, rx_state_code, tx_state_code;
  logic [2:0]           hsize;
  wire logic            hready = hreadyout;
  cie_pkg::cie_events_t events;
  cie_pkg::cie_irq_t    irq_req;
  logic [31:0]          exp_q[$];
  int                   failures, checks, cyc;
  integer               seed;
  cie_top DUT (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .init_acknowledge, .events, .rx_state_code,
    .tx_state_code, .init_request, .wakeup_function_en, .irq_req, .irq);
  always #20 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (e !== s) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one single transfer, read data noted for the monitor
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {26'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) exp_q.push_back(d);
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  task automatic settle_chk(input string n, input logic [31:0] e);
    repeat (3) @(posedge clk);
    chk(n, e, (n == "irq") ? {31'h0, irq} : {29'h0, irq_req});
  endtask
  always @(posedge clk) begin
    if (rd_dp) chk("hrdata", exp_q.pop_front(), hrdata);
    rd_dp = hsel && htrans[1] && !hwrite && hreadyout && !sys_rst;
    cyc++;
    if (cyc == 3000) begin
      failures++;
      final_report;
    end
  end
  initial begin
    seed = 32'h6cc0a523;
    {clk, hsel, hwrite, init_acknowledge, rd_dp} = 5'h00;
    {haddr, hwdata, htrans, rx_state_code, tx_state_code, events} = '0;
    sys_rst = 1'b1;
    hsize = 3'h2;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    xfer(1'b0, EN, {24'h0, cie_pkg::CIE_ENABLE_RST});
    xfer(1'b0, 6'h3C, 32'h0);
    repeat (3) begin
      v = $random(seed);
      xfer(1'b1, EN, v);
      xfer(1'b0, EN, {24'h0, v[7:0]});
    end
    xfer(1'b1, CT, 32'h1);
    init_acknowledge <= 1'b1;
    repeat (2) @(posedge clk);
    xfer(1'b0, EN, {24'h0, v[7:0] & 8'h3C});
    xfer(1'b1, EN, 32'hFF);
    xfer(1'b0, EN, 32'h3C);
    init_acknowledge <= 1'b0;
    xfer(1'b1, CT, 32'h2);
    xfer(1'b1, EN, 32'h7F);
    events <= 3'h7;
    @(posedge clk);
    events <= 3'h0;
    xfer(1'b0, ST, 32'h7);
    settle_chk("irq_req", 32'h3);
    xfer(1'b1, EN, 32'hFF);
    settle_chk("irq_req", 32'h7);
    xfer(1'b0, IS, 32'hB);
    xfer(1'b1, IM, 32'hF);
    settle_chk("irq", 32'h1);
    xfer(1'b1, IM, 32'h0);
    settle_chk("irq", 32'h0);
    xfer(1'b1, IM, 32'hF);
    xfer(1'b1, IS, 32'hF);
    settle_chk("irq", 32'h0);
    xfer(1'b1, ST, 32'h7);
    xfer(1'b1, EN, 32'h50);
    rx_state_code <= 2'h1;
    settle_chk("irq_req", 32'h0);
    xfer(1'b0, ST, 32'h200);
    rx_state_code <= 2'h3;
    settle_chk("irq_req", 32'h2);
    xfer(1'b0, ST, 32'h700);
    rx_state_code <= 2'h0;
    xfer(1'b0, ST, 32'h700);
    rx_state_code <= 2'h3;
    xfer(1'b1, ST, 32'h100);
    xfer(1'b0, ST, 32'h600);
    xfer(1'b1, EN, 32'h48);
    tx_state_code <= 2'h1;
    @(posedge clk);
    xfer(1'b0, ST, 32'hE00);
    tx_state_code <= 2'h2;
    @(posedge clk);
    xfer(1'b0, ST, 32'h1700);
    xfer(1'b1, ST, 32'h100);
    tx_state_code <= 2'h3;
    @(posedge clk);
    xfer(1'b0, ST, 32'h1E00);
    tx_state_code <= 2'h0;
    @(posedge clk);
    xfer(1'b0, ST, 32'h100);
    @(posedge clk);
    final_report;
  end
endmodule // cie_top_tb
